// [verilog/cbs_exec.v]
`timescale 1ns/1ns
// Overview of operation
// - Compare immediate subtracts constant, sets Z N V C H (and S), one cycle.
// - Register bit skip tests a bit, skips when clear or set, flags kept.
// - I/O bit skip tests an I/O bit, skips when clear or set, flags kept.
// - Skip passes whole next instruction: one or two extra cycles by its length.
// - Generic flag branch picks status bit by index, taken target PC+k+1.
// - Zero and carry branches are generic branches, 1 cycle untaken, 2 taken.
// - Signed branches test N xor V; minus and plus test N alone.
// - Half-carry branches test H, 1 or 2 cycles, no flags touched.
// - Transfer-bit branches test T, 1 or 2 cycles.
// - Overflow branches test V, same target and timing.
// - Interrupt-state branches test I, 1 or 2 cycles.
// - Indirect load reads memory at pointer in 2 cycles; post-inc bumps pointer.
// - Pre-decrement load decrements pointer first, reads new address, 2 cycles.
// - Displacement load reads Y or Z plus displacement, pointer unchanged.
`include "cbs_map.vh"
module cbs_exec #(
    parameter PC_W = 13
) (
    input wire i_sys_clk,
    input wire i_sys_rst,
    input wire i_issue,
    input wire [3:0] i_op,
    input wire [PC_W-1:0] i_pc,
    input wire [7:0] i_reg_val,
    input wire [7:0] i_imm,
    input wire [2:0] i_bit_sel,
    input wire [6:0] i_offset,
    input wire [7:0] i_io_val,
    input wire i_next_two_word,
    input wire [4:0] i_dest,
    input wire [1:0] i_ptr_sel,
    input wire [5:0] i_disp,
    input wire [15:0] i_ptr_val,
    input wire [7:0] i_mem_rdata,
    input wire [7:0] i_status_register,
    output wire o_busy,
    output reg o_flush,
    output reg o_pc_load,
    output reg [PC_W-1:0] o_pc_target,
    output reg o_flags_we,
    output reg [7:0] o_flags,
    output reg o_mem_rd,
    output reg [15:0] o_mem_addr,
    output reg o_ptr_we,
    output reg [1:0] o_ptr_sel,
    output reg [15:0] o_ptr_wdata,
    output reg o_reg_we,
    output reg [4:0] o_reg_addr,
    output reg [7:0] o_reg_wdata
);
    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_LOAD = 2'h2;

    reg [1:0] state;
    reg [1:0] wait_cnt;
    reg [4:0] load_dest;

    function [PC_W-1:0] rel_target;
        input [PC_W-1:0] pc;
        input [6:0] k;
        begin
            rel_target = pc + {{(PC_W-7){k[6]}}, k} + 1'b1;
        end
    endfunction

    // Instruction stays issued only in the idle state; extra cycles hold o_busy.
    assign o_busy = (state != ST_IDLE);

    wire take = i_issue && !o_busy;

    // ------------------------------------------------------------------------
    // Compare flags
    // ------------------------------------------------------------------------
    // The subtraction is one bit wider so that the borrow out of bit 7 is the carry.
    // Half-carry and overflow follow the borrow equations, so a compare leaves the
    // same flags as a subtract would while no register is written.
    wire [8:0] diff = {1'b0, i_reg_val} - {1'b0, i_imm};
    wire [7:0] res = diff[7:0];
    wire f_h = (~i_reg_val[3] & i_imm[3]) | (i_imm[3] & res[3]) | (res[3] & ~i_reg_val[3]);
    wire f_v = (i_reg_val[7] & ~i_imm[7] & ~res[7]) | (~i_reg_val[7] & i_imm[7] & res[7]);
    wire f_n = res[7];
    wire f_z = (res == 8'h00);
    wire f_c = diff[8];

    // ------------------------------------------------------------------------
    // Skip and branch decisions
    // ------------------------------------------------------------------------
    // The generic flag branches stand in for the named ones: the fetch side turns the
    // equal, carry, minus, half-carry, transfer, overflow and interrupt forms into an index.
    wire sel_bit = i_status_register[i_bit_sel];
    wire s_flag = i_status_register[`CBS_FLAG_N] ^ i_status_register[`CBS_FLAG_V];
    wire reg_bit = i_reg_val[i_bit_sel];
    wire io_bit = i_io_val[i_bit_sel];

    reg skip;
    reg branch;
    always @* begin
        skip = 1'b0;
        branch = 1'b0;
        case (i_op)
            `CBS_OP_SKIP_REG_BIT_CLEAR: skip = !reg_bit;
            `CBS_OP_SKIP_REG_BIT_SET: skip = reg_bit;
            `CBS_OP_SKIP_IO_BIT_CLEAR: skip = !io_bit;
            `CBS_OP_SKIP_IO_BIT_SET: skip = io_bit;
            `CBS_OP_BRANCH_FLAG_SET: branch = sel_bit;
            `CBS_OP_BRANCH_FLAG_CLEAR: branch = !sel_bit;
            `CBS_OP_BRANCH_SIGNED_GE: branch = !s_flag;
            `CBS_OP_BRANCH_SIGNED_LT: branch = s_flag;
            default: begin
                skip = 1'b0;
                branch = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Load address
    // ------------------------------------------------------------------------
    // Pre-decrement reads at the new pointer value, so address and write-back share one
    // decrementer. The displacement form never writes the pointer back.
    wire is_load = (i_op == `CBS_OP_LOAD_INDIRECT) || (i_op == `CBS_OP_LOAD_POST_INC) ||
        (i_op == `CBS_OP_LOAD_PRE_DEC) || (i_op == `CBS_OP_LOAD_DISPLACED);
    wire [15:0] ptr_dec = i_ptr_val - 16'h0001;
    wire [15:0] ptr_inc = i_ptr_val + 16'h0001;

    reg [15:0] load_addr;
    always @* begin
        load_addr = i_ptr_val;
        if (i_op == `CBS_OP_LOAD_PRE_DEC) begin
            load_addr = ptr_dec;
        end else if (i_op == `CBS_OP_LOAD_DISPLACED) begin
            load_addr = i_ptr_val + {10'h000, i_disp};
        end
    end

    // ------------------------------------------------------------------------
    // Execution
    // ------------------------------------------------------------------------
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            wait_cnt <= 2'h0;
            load_dest <= 5'h00;
            o_flush <= 1'b0;
            o_pc_load <= 1'b0;
            o_pc_target <= {PC_W{1'b0}};
            o_flags_we <= 1'b0;
            o_flags <= 8'h00;
            o_mem_rd <= 1'b0;
            o_mem_addr <= 16'h0000;
            o_ptr_we <= 1'b0;
            o_ptr_sel <= 2'h0;
            o_ptr_wdata <= 16'h0000;
            o_reg_we <= 1'b0;
            o_reg_addr <= 5'h00;
            o_reg_wdata <= 8'h00;
        end else begin
            o_flush <= 1'b0;
            o_pc_load <= 1'b0;
            o_flags_we <= 1'b0;
            o_mem_rd <= 1'b0;
            o_ptr_we <= 1'b0;
            o_reg_we <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (take && i_op == `CBS_OP_CMP_IMMEDIATE) begin
                        o_flags_we <= 1'b1;
                        o_flags <= {i_status_register[7:6], f_h, f_n ^ f_v, f_v, f_n, f_z, f_c};
                    end else if (take && skip) begin
                        o_pc_load <= 1'b1;
                        o_flush <= 1'b1;
                        // The fetch side reports the next instruction's length; it is unseen here.
                        o_pc_target <= i_pc + (i_next_two_word ? 3'h3 : 3'h2);
                        wait_cnt <= i_next_two_word ? 2'h2 : 2'h1;
                        state <= ST_WAIT;
                    end else if (take && branch) begin
                        o_pc_load <= 1'b1;
                        o_flush <= 1'b1;
                        o_pc_target <= rel_target(i_pc, i_offset);
                        wait_cnt <= `CBS_CYC_BRANCH_TAKEN - 2'h1;
                        state <= ST_WAIT;
                    end else if (take && is_load) begin
                        o_mem_rd <= 1'b1;
                        o_mem_addr <= load_addr;
                        load_dest <= i_dest;
                        o_ptr_sel <= i_ptr_sel;
                        if (i_op == `CBS_OP_LOAD_POST_INC) begin
                            o_ptr_we <= 1'b1;
                            o_ptr_wdata <= ptr_inc;
                        end else if (i_op == `CBS_OP_LOAD_PRE_DEC) begin
                            o_ptr_we <= 1'b1;
                            o_ptr_wdata <= ptr_dec;
                        end
                        state <= ST_LOAD;
                    end
                end
                // The issue cycle is the first cycle, so the count holds only the extra ones.
                // An issue offered meanwhile stays pending because o_busy is high.
                ST_WAIT: begin
                    wait_cnt <= wait_cnt - 2'h1;
                    if (wait_cnt == 2'h1) begin
                        state <= ST_IDLE;
                    end
                end
                ST_LOAD: begin
                    o_reg_we <= 1'b1;
                    o_reg_addr <= load_dest;
                    o_reg_wdata <= i_mem_rdata;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// [verilog/cbs_map.vh]
`ifndef CBS_MAP_VH
`define CBS_MAP_VH
// ----------------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------------
`define CBS_FLAG_C 3'h0
`define CBS_FLAG_Z 3'h1
`define CBS_FLAG_N 3'h2
`define CBS_FLAG_V 3'h3
`define CBS_FLAG_S 3'h4
`define CBS_FLAG_H 3'h5
`define CBS_FLAG_T 3'h6
`define CBS_FLAG_I 3'h7
// ----------------------------------------------------------------------------
// Operation select codes on i_op
// ----------------------------------------------------------------------------
`define CBS_OP_NOP 4'h0
`define CBS_OP_CMP_IMMEDIATE 4'h1
`define CBS_OP_SKIP_REG_BIT_CLEAR 4'h2
`define CBS_OP_SKIP_REG_BIT_SET 4'h3
`define CBS_OP_SKIP_IO_BIT_CLEAR 4'h4
`define CBS_OP_SKIP_IO_BIT_SET 4'h5
`define CBS_OP_BRANCH_FLAG_SET 4'h6
`define CBS_OP_BRANCH_FLAG_CLEAR 4'h7
`define CBS_OP_BRANCH_SIGNED_GE 4'h8
`define CBS_OP_BRANCH_SIGNED_LT 4'h9
`define CBS_OP_LOAD_INDIRECT 4'hA
`define CBS_OP_LOAD_POST_INC 4'hB
`define CBS_OP_LOAD_PRE_DEC 4'hC
`define CBS_OP_LOAD_DISPLACED 4'hD
// ----------------------------------------------------------------------------
// Pointer pair select
// ----------------------------------------------------------------------------
`define CBS_PTR_X 2'h0
`define CBS_PTR_Y 2'h1
`define CBS_PTR_Z 2'h2
// ----------------------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------------------
`define CBS_CYC_BRANCH_TAKEN 2'h2
`define CBS_CYC_LOAD 2'h2
`endif

// [verification/cbs_exec_assertions.sv]
`timescale 1ns/1ns
`include "cbs_map.vh"
module cbs_exec_chk #(parameter PC_W = 13) (
    input wire i_sys_clk, i_sys_rst, i_issue, i_next_two_word, o_busy,
    input wire o_flush, o_pc_load, o_flags_we, o_mem_rd, o_ptr_we, o_reg_we,
    input wire [3:0] i_op,
    input wire [PC_W-1:0] i_pc, o_pc_target,
    input wire [2:0] i_bit_sel,
    input wire [6:0] i_offset,
    input wire [7:0] i_status_register, i_io_val, i_reg_val,
    input wire [1:0] i_ptr_sel, o_ptr_sel,
    input wire [15:0] i_ptr_val, o_mem_addr, o_ptr_wdata
);
    // ----
    // Properties
    // ----
    wire go = i_issue && !o_busy;
    wire hit = i_status_register[i_bit_sel];
    wire nv = i_status_register[2] ^ i_status_register[3];
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    chk_branch_target: assert property (go && i_op == `CBS_OP_BRANCH_FLAG_SET && hit |=>
        o_pc_load && o_flush && o_pc_target == PC_W'($past(i_pc)
        + PC_W'($signed($past(i_offset))) + 1)) else $error("branch target wrong");
    chk_untaken_quiet: assert property (go && i_op == `CBS_OP_BRANCH_FLAG_CLEAR
        && hit |=> !o_pc_load && !o_busy) else $error("untaken branch acted");
    chk_taken_busy: assert property (go && i_op == `CBS_OP_BRANCH_FLAG_CLEAR && !hit |=>
        o_busy && o_pc_load ##1 !o_busy) else $error("taken branch timing wrong");
    chk_signed_lt: assert property (go && i_op == `CBS_OP_BRANCH_SIGNED_LT |=>
        o_pc_load == $past(nv)) else $error("signed lt decision wrong");
    chk_signed_ge: assert property (go && i_op == `CBS_OP_BRANCH_SIGNED_GE |=>
        o_pc_load != $past(nv)) else $error("signed ge decision wrong");
    chk_io_skip: assert property (go && i_op == `CBS_OP_SKIP_IO_BIT_SET
        && i_io_val[i_bit_sel] |=> o_pc_load && o_flush
        && o_pc_target == PC_W'($past(i_pc) + 2 + $past(i_next_two_word)))
        else $error("io skip target wrong");
    chk_reg_skip: assert property (go && i_op == `CBS_OP_SKIP_REG_BIT_CLEAR
        && !i_reg_val[i_bit_sel] |=> o_pc_load && o_flush
        && o_pc_target == PC_W'($past(i_pc) + 2 + $past(i_next_two_word)))
        else $error("register skip target wrong");
    chk_skip_long: assert property (go && i_op == `CBS_OP_SKIP_IO_BIT_CLEAR
        && !i_io_val[i_bit_sel] && i_next_two_word |=> o_busy[*2] ##1 !o_busy)
        else $error("long skip timing wrong");
    chk_flags_kept: assert property (go && i_op inside {[4'h2:4'h9]} |=> !o_flags_we)
        else $error("skip or branch wrote flags");
    chk_pre_dec: assert property (go && i_op == `CBS_OP_LOAD_PRE_DEC
        |=> o_mem_rd && o_ptr_we && o_mem_addr == $past(i_ptr_val) - 16'h1
        && o_ptr_wdata == o_mem_addr) else $error("pre-decrement load wrong");
    chk_post_inc: assert property (go && i_op == `CBS_OP_LOAD_POST_INC |=> o_mem_rd
        && o_ptr_we && o_mem_addr == $past(i_ptr_val)
        && o_ptr_wdata == $past(i_ptr_val) + 16'h1 ##1 o_reg_we)
        else $error("post-increment load wrong");
    chk_disp_keep: assert property (go && i_op == `CBS_OP_LOAD_DISPLACED |=> o_mem_rd
        && !o_ptr_we ##1 o_reg_we && !o_busy) else $error("displaced load wrong");
    chk_plain_load: assert property (go && i_op == `CBS_OP_LOAD_INDIRECT |=> o_mem_rd
        && !o_ptr_we && o_mem_addr == $past(i_ptr_val)) else $error("plain load wrong");
    chk_ptr_select: assert property (go && i_op inside {[4'hA:4'hD]} |=>
        o_ptr_sel == $past(i_ptr_sel)) else $error("pointer select not passed on");
    cover property (go && i_op == `CBS_OP_SKIP_REG_BIT_SET && i_reg_val[i_bit_sel]);
    cover property (go && i_op == `CBS_OP_LOAD_PRE_DEC);
    cover property (go && i_op == `CBS_OP_CMP_IMMEDIATE);
    cover property (o_pc_load && i_next_two_word);
endmodule
bind cbs_exec cbs_exec_chk #(.PC_W(PC_W)) i_cbs_exec_chk (.*);

// [verification/cbs_mem_model.sv]
`timescale 1ns/1ns
module cbs_mem_model (
    input wire i_sys_clk,
    input wire i_mem_rd,
    input wire [15:0] i_mem_addr,
    output logic [7:0] o_mem_rdata
);
    // Outside a read the bus shows a changing pattern, so a late sample is caught.
    logic [7:0] junk = 8'h3C;
    always @(posedge i_sys_clk) junk <= ~junk + 8'h1;
    always @* o_mem_rdata = i_mem_rd ? (i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ 8'hA5) : junk;
endmodule

// [verification/cbs_exec_test.sv]
`timescale 1ns/1ns
`include "cbs_map.vh"
module cbs_exec_test;
    logic i_sys_clk = 0, i_sys_rst = 1, i_issue = 0, i_next_two_word = 0, b, c;
    logic [3:0] i_op = 0;
    logic [12:0] i_pc = 0, tg;
    logic [7:0] i_reg_val = 0, i_imm = 0, i_io_val = 0, i_status_register = 0;
    logic [2:0] i_bit_sel = 0;
    logic [6:0] i_offset = 0;
    logic [4:0] i_dest = 0;
    logic [1:0] i_ptr_sel = 0;
    logic [5:0] i_disp = 0;
    logic [15:0] i_ptr_val = 0, a, q_pc[$], q_flg[$], q_reg[$];
    logic [31:0] r, s, t;
    wire o_busy, o_flush, o_pc_load, o_flags_we, o_mem_rd, o_ptr_we, o_reg_we;
    wire [12:0] o_pc_target;
    wire [7:0] o_flags, o_reg_wdata, i_mem_rdata;
    wire [15:0] o_mem_addr, o_ptr_wdata;
    wire [1:0] o_ptr_sel;
    wire [4:0] o_reg_addr;
    integer n_mismatch = 0, tests_run = 0, seed = 59601;
    cbs_exec #(.PC_W(13)) i_cbs_exec (.*);
    cbs_mem_model i_cbs_mem_model (.i_sys_clk, .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
        .o_mem_rdata(i_mem_rdata));
    always #25 i_sys_clk = ~i_sys_clk;
    // ----
    // Checking
    // ----
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cmp_pc(input logic [15:0] got, input logic [15:0] exp);
        cmp(got, exp);
    endtask
    task cmp_flg(input logic [15:0] got, input logic [15:0] exp);
        cmp(got, exp);
    endtask
    task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
        cmp(got, exp);
    endtask
    task give_verdict;
        n_mismatch += q_pc.size() + q_flg.size() + q_reg.size();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function logic [15:0] cmpf(input logic [7:0] x, k, sr);
        logic [7:0] d;
        logic h, v;
        d = x - k;
        h = (!x[3] & k[3]) | (k[3] & d[3]) | (d[3] & !x[3]);
        v = (x[7] & !k[7] & !d[7]) | (!x[7] & k[7] & d[7]);
        return {8'h00, sr[7:6], h, d[7] ^ v, v, d[7], d == 8'h00, x < k};
    endfunction
    // Sampled mid-cycle so the registered pulses have settled.
    always @(negedge i_sys_clk) begin
        if (o_pc_load) cmp_pc(o_pc_target, q_pc.size() ? q_pc.pop_front() : 16'hXXXX);
        if (o_flags_we) cmp_flg(o_flags, q_flg.size() ? q_flg.pop_front() : 16'hXXXX);
        if (o_reg_we) cmp_reg({o_reg_addr, o_reg_wdata},
            q_reg.size() ? q_reg.pop_front() : 16'hXXXX);
    end
    initial begin
        #200000;
        n_mismatch++;
        give_verdict;
    end
    // ----
    // Stimulus
    // ----
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_sys_rst <= 0;
        repeat (300) begin
            r = $random(seed);
            s = $random(seed);
            t = $random(seed);
            case (r[3:0])
                4'h2: c = !s[r[19:17]];
                4'h3: c = s[r[19:17]];
                4'h4: c = !s[16 + r[19:17]];
                4'h5: c = s[16 + r[19:17]];
                4'h6: c = s[24 + r[19:17]];
                4'h7: c = !s[24 + r[19:17]];
                4'h8: c = !(s[26] ^ s[27]);
                4'h9: c = s[26] ^ s[27];
                default: c = 0;
            endcase
            tg = r[3:0] < 4'h6 ? r[16:4] + 13'h2 + r[27] :
                r[16:4] + {{6{r[26]}}, r[26:20]} + 13'h1;
            if (c) q_pc.push_back({3'h0, tg});
            if (r[3:0] == `CBS_OP_CMP_IMMEDIATE) q_flg.push_back(cmpf(s[7:0], s[15:8], s[31:24]));
            a = r[3:0] == `CBS_OP_LOAD_PRE_DEC ? t[15:0] - 16'h1 :
                r[3:0] == `CBS_OP_LOAD_DISPLACED ? t[15:0] + t[21:16] : t[15:0];
            if (r[3:0] >= 4'hA && r[3:0] <= 4'hD)
                q_reg.push_back({3'h0, r[31:27], a[7:0] ^ a[15:8] ^ 8'hA5});
            i_issue <= 1;
            i_op <= r[3:0];
            i_pc <= r[16:4];
            i_bit_sel <= r[19:17];
            i_offset <= r[26:20];
            i_next_two_word <= r[27];
            i_dest <= r[31:27];
            i_ptr_sel <= r[28] ? 2'h2 : {1'b0, r[3:0] == `CBS_OP_LOAD_DISPLACED};
            {i_status_register, i_io_val, i_imm, i_reg_val} <= s;
            i_ptr_val <= t[15:0];
            i_disp <= t[21:16];
            do begin
                @(negedge i_sys_clk) b = o_busy;
                @(posedge i_sys_clk);
            end while (b);
        end
        i_issue <= 0;
        repeat (4) @(posedge i_sys_clk);
        give_verdict;
    end
endmodule
